// File: hw/cppm_pkg.sv
// Function
// - enable set, bus low over 2s: Sleep
// - swap disable command with swap enabled: Sleep
// - enable set, swap clear, bus high: Active
// - power switch low wakes to Active
// - charger present, swap clear: wake Active
// - swap enable command with swap enabled: Active
// - start in Sleep after power up
// - overvoltage delay: charge off, flag set
// - overvoltage releases below charge enable level
// - undervoltage delay: both off, flag, Sleep
// - positive overcurrent delay: both off, flag
// - charge trip: pull down until released
// - negative overcurrent: discharge off, pull up
// - short circuit: discharge off, same release
// - discharge off is OR of causes
// - charge off is OR of causes
// - Active only: 128-reading average current
// - clamp average to register range
// - positive means charging, negative discharging
// - current register LSB fixed scale
// - accumulator counts up charge, down discharge
// - host write replaces accumulator
// - flags sticky until host clears
package cppm_pkg;
    // register indexes, byte address is four times the index
    localparam logic [7:0] IDX_PROT   = 8'h00;
    localparam logic [7:0] IDX_STAT   = 8'h01;
    localparam logic [7:0] IDX_SPEC   = 8'h08;
    localparam logic [7:0] IDX_CURR   = 8'h0e;
    localparam logic [7:0] IDX_ACC    = 8'h10;
    // protection register fields
    localparam int B_OV  = 7;
    localparam int B_UV  = 6;
    localparam int B_COC = 5;
    localparam int B_DOC = 4;
    localparam int B_CC  = 3;
    localparam int B_DC  = 2;
    localparam int B_CE  = 1;
    localparam int B_DE  = 0;
    localparam logic [7:0] PROT_RST = 8'h03;
    // status and special feature fields
    localparam int B_DISCONNECT_SLEEP_ENABLE  = 5;
    localparam int B_SWAP_ENABLE  = 3;
    localparam int B_PSN   = 7;
    localparam int B_SLEEP = 6;
    localparam int B_SWDIS = 1;
    localparam int B_SWENA = 0;
    // timing
    localparam int CLK_HZ        = 20_000_000;
    localparam int BUS_LOW_MS    = 2000;
    localparam int OVD_MS        = 1000;
    localparam int UVD_MS        = 100;
    localparam int OCD_MS        = 10;
    localparam int SCD_US        = 100;
    localparam int BUS_LOW_CYC   = BUS_LOW_MS * (CLK_HZ / 1000);
    localparam int OVD_CYC       = OVD_MS * (CLK_HZ / 1000);
    localparam int UVD_CYC       = UVD_MS * (CLK_HZ / 1000);
    localparam int OCD_CYC       = OCD_MS * (CLK_HZ / 1000);
    localparam int SCD_CYC       = SCD_US * (CLK_HZ / 1_000_000);
    // measurement
    localparam int AVG_LOG2      = 7;
    localparam logic signed [11:0] CURR_MAX = 12'sh7ff;
    localparam logic signed [11:0] CURR_MIN = -12'sh800;
    // 0.25mAh per accumulator LSB over 0.625mA x 88ms updates
    localparam int ACC_UNIT      = 900_000 / 55;
    // comparator results from the analog front end
    typedef struct packed {
        logic cell_above_ov;
        logic cell_below_ce;
        logic cell_below_uv;
        logic sense_over_pos;
        logic sense_under_neg;
        logic short_detect;
        logic charger_present;
        logic pls_below_test;
        logic pls_above_test;
    } cppm_sense_t;
endpackage

// File: hw/cppm_top.sv
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
module cppm_top #(
    parameter int BUS_LOW_CYCLES = cppm_pkg::BUS_LOW_CYC,
    parameter int OVD_CYCLES     = cppm_pkg::OVD_CYC,
    parameter int UVD_CYCLES     = cppm_pkg::UVD_CYC,
    parameter int OCD_CYCLES     = cppm_pkg::OCD_CYC
) (
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [9:0]            paddr_i,
    input  wire logic [31:0]           pwdata_i,
    output logic                       pready_o,
    output logic [31:0]                prdata_o,
    output logic                       pslverr_o,
    input  wire cppm_pkg::cppm_sense_t sense_i,
    input  wire logic                  bus_data_i,
    input  wire logic                  power_switch_input_n_i,
    input  wire logic                  sample_valid_i,
    input  wire logic signed [15:0]    sample_i,
    output logic                       charge_fet_off_o,
    output logic                       discharge_fet_off_o,
    output logic                       pls_pulldown_o,
    output logic                       pls_pullup_o,
    output logic                       sleep_o
);
    import cppm_pkg::*;

    typedef enum logic {ST_ACTIVE, ST_SLEEP} cppm_state_t;

    //--------------------------------------------------------------
    // declarations
    //--------------------------------------------------------------
    cppm_state_t        state_r;
    logic [7:0]         prot_r;
    logic               disconnect_sleep_enable_r;
    logic               swap_enable_r;
    logic               ov_trip_r;
    logic               uv_trip_r;
    logic               coc_trip_r;
    logic               doc_trip_r;
    logic [31:0]        bus_cnt_r;
    logic [31:0]        ov_cnt_r;
    logic [31:0]        uv_cnt_r;
    logic [31:0]        oc_pos_cnt_r;
    logic [31:0]        oc_neg_cnt_r;
    logic [31:0]        sc_cnt_r;
    logic signed [23:0] sum_r;
    logic [6:0]         avg_cnt_r;
    logic signed [11:0] curr_r;
    logic               curr_upd_r;
    logic signed [15:0] acc_r;
    logic signed [19:0] frac_r;
    logic               pready_r;
    logic [31:0]        prdata_r;
    logic               pslverr_r;
    logic               cc_off_r;
    logic               dc_off_r;
    logic               wr_en;
    logic               rd_en;
    logic [7:0]         idx;
    logic               active;
    logic               bus_low_exp;
    logic               ov_exp;
    logic               uv_exp;
    logic               ocp_exp;
    logic               ocn_exp;
    logic               sc_exp;
    logic               swap_dis;
    logic               swap_ena;
    logic               go_sleep;
    logic               wake;

    // qualified delay counter, restarts when its condition drops
    function automatic logic [31:0] tmr_step(input logic cond, input logic [31:0] cnt,
                                             input int limit);
        if (!cond)
            return 32'h0;
        else if (cnt >= 32'(limit))
            return cnt;
        else
            return cnt + 32'h1;
    endfunction

    //--------------------------------------------------------------
    // apb decode
    //--------------------------------------------------------------
    // one wait state: answer in the second access cycle
    assign idx    = paddr_i[9:2];
    assign wr_en  = psel_i && penable_i && !pready_r && pwrite_i;
    assign rd_en  = psel_i && penable_i && !pready_r && !pwrite_i;
    assign active = (state_r == ST_ACTIVE);

    // swap commands are write pulses into the special feature register
    assign swap_dis = wr_en && idx == IDX_SPEC && pwdata_i[B_SWDIS] && swap_enable_r;
    assign swap_ena = wr_en && idx == IDX_SPEC && pwdata_i[B_SWENA] && swap_enable_r;

    // ready, read data and error answer
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r  <= psel_i && penable_i && !pready_r;
            pslverr_r <= 1'b0;
            if (psel_i && penable_i && !pready_r)
            begin
                prdata_r <= 32'h0;
                unique case (idx)
                    IDX_PROT: prdata_r <= {24'h0, prot_r};
                    IDX_STAT: prdata_r <= {24'h0, 2'b00, disconnect_sleep_enable_r, 1'b0, swap_enable_r, 3'b000};
                    IDX_SPEC: prdata_r <= {24'h0, power_switch_input_n_i, !active, 6'h0};
                    IDX_CURR: prdata_r <= {20'h0, curr_r};
                    IDX_ACC:  prdata_r <= {16'h0, acc_r};
                    default:  pslverr_r <= 1'b1;
                endcase
                if (pwrite_i)
                    prdata_r <= 32'h0;
            end
        end
    end

    //--------------------------------------------------------------
    // status register
    //--------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            disconnect_sleep_enable_r <= 1'b0;
            swap_enable_r <= 1'b0;
        end
        else if (wr_en && idx == IDX_STAT)
        begin
            disconnect_sleep_enable_r <= pwdata_i[B_DISCONNECT_SLEEP_ENABLE];
            swap_enable_r <= pwdata_i[B_SWAP_ENABLE];
        end
    end

    //--------------------------------------------------------------
    // delay counters
    //--------------------------------------------------------------
    // bus-low timer runs in both modes
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            bus_cnt_r <= 32'h0;
        else
            bus_cnt_r <= tmr_step(!bus_data_i, bus_cnt_r, BUS_LOW_CYCLES);
    end

    // protection timers only count in Active
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            ov_cnt_r     <= 32'h0;
            uv_cnt_r     <= 32'h0;
            oc_pos_cnt_r <= 32'h0;
            oc_neg_cnt_r <= 32'h0;
            sc_cnt_r     <= 32'h0;
        end
        else
        begin
            ov_cnt_r     <= tmr_step(active && sense_i.cell_above_ov, ov_cnt_r, OVD_CYCLES);
            uv_cnt_r     <= tmr_step(active && sense_i.cell_below_uv, uv_cnt_r, UVD_CYCLES);
            oc_pos_cnt_r <= tmr_step(active && sense_i.sense_over_pos, oc_pos_cnt_r, OCD_CYCLES);
            oc_neg_cnt_r <= tmr_step(active && sense_i.sense_under_neg, oc_neg_cnt_r, OCD_CYCLES);
            sc_cnt_r     <= tmr_step(active && sense_i.short_detect, sc_cnt_r, SCD_CYC);
        end
    end

    assign bus_low_exp = bus_cnt_r >= 32'(BUS_LOW_CYCLES);
    assign ov_exp      = ov_cnt_r >= 32'(OVD_CYCLES);
    assign uv_exp      = uv_cnt_r >= 32'(UVD_CYCLES);
    assign ocp_exp     = oc_pos_cnt_r >= 32'(OCD_CYCLES);
    assign ocn_exp     = oc_neg_cnt_r >= 32'(OCD_CYCLES);
    assign sc_exp      = sc_cnt_r >= 32'(SCD_CYC);

    //--------------------------------------------------------------
    // power mode
    //--------------------------------------------------------------
    assign go_sleep = (disconnect_sleep_enable_r && bus_low_exp) || uv_exp || swap_dis;
    assign wake = (disconnect_sleep_enable_r && !swap_enable_r && bus_data_i)
                || !power_switch_input_n_i
                || (sense_i.charger_present && !swap_enable_r)
                || swap_ena;

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            state_r <= ST_SLEEP;
        else
            unique case (state_r)
                ST_ACTIVE: if (go_sleep) state_r <= ST_SLEEP;
                ST_SLEEP:  if (wake) state_r <= ST_ACTIVE;
            endcase
    end

    //--------------------------------------------------------------
    // protection trips and releases
    //--------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            ov_trip_r  <= 1'b0;
            uv_trip_r  <= 1'b0;
            coc_trip_r <= 1'b0;
            doc_trip_r <= 1'b0;
        end
        else
        begin
            if (ov_exp)
                ov_trip_r <= 1'b1;
            else if (sense_i.cell_below_ce)
                ov_trip_r <= 1'b0;
            if (uv_exp)
                uv_trip_r <= 1'b1;
            else if (sense_i.charger_present)
                uv_trip_r <= 1'b0;
            if (ocp_exp)
                coc_trip_r <= 1'b1;
            else if (sense_i.pls_below_test)
                coc_trip_r <= 1'b0;
            if (ocn_exp || sc_exp)
                doc_trip_r <= 1'b1;
            else if (sense_i.pls_above_test)
                doc_trip_r <= 1'b0;
        end
    end

    // protection register: sticky flags, host clears by writing 0
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            prot_r <= PROT_RST;
        else
        begin
            if (wr_en && idx == IDX_PROT)
            begin
                prot_r[B_CE] <= pwdata_i[B_CE];
                prot_r[B_DE] <= pwdata_i[B_DE];
                prot_r[B_OV]  <= (prot_r[B_OV] && pwdata_i[B_OV]) || ov_exp;
                prot_r[B_UV]  <= (prot_r[B_UV] && pwdata_i[B_UV]) || uv_exp;
                prot_r[B_COC] <= (prot_r[B_COC] && pwdata_i[B_COC]) || ocp_exp;
                prot_r[B_DOC] <= (prot_r[B_DOC] && pwdata_i[B_DOC]) || ocn_exp || sc_exp;
            end
            else
            begin
                prot_r[B_OV]  <= prot_r[B_OV] || ov_exp;
                prot_r[B_UV]  <= prot_r[B_UV] || uv_exp;
                prot_r[B_COC] <= prot_r[B_COC] || ocp_exp;
                prot_r[B_DOC] <= prot_r[B_DOC] || ocn_exp || sc_exp;
            end
            prot_r[B_CC] <= cc_off_r;
            prot_r[B_DC] <= dc_off_r;
        end
    end

    //--------------------------------------------------------------
    // fet controls and pack test currents
    //--------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            cc_off_r       <= 1'b1;
            dc_off_r       <= 1'b1;
            pls_pulldown_o <= 1'b0;
            pls_pullup_o   <= 1'b0;
        end
        else
        begin
            cc_off_r <= ov_trip_r || uv_trip_r || coc_trip_r
                      || !prot_r[B_CE] || !active;
            dc_off_r <= uv_trip_r || coc_trip_r || doc_trip_r
                      || !prot_r[B_DE] || !active;
            pls_pulldown_o <= coc_trip_r;
            pls_pullup_o   <= doc_trip_r;
        end
    end

    assign charge_fet_off_o    = cc_off_r;
    assign discharge_fet_off_o = dc_off_r;
    assign sleep_o             = (state_r == ST_SLEEP);

    //--------------------------------------------------------------
    // current averaging
    //--------------------------------------------------------------
    // sum 128 readings in Active, then store the clamped mean
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            sum_r      <= 24'sh0;
            avg_cnt_r  <= 7'h0;
            curr_r     <= 12'sh0;
            curr_upd_r <= 1'b0;
        end
        else
        begin
            curr_upd_r <= 1'b0;
            if (!active)
            begin
                sum_r     <= 24'sh0;
                avg_cnt_r <= 7'h0;
            end
            else if (sample_valid_i)
            begin
                avg_cnt_r <= avg_cnt_r + 7'h1;
                if (avg_cnt_r == 7'h7f)
                begin
                    sum_r      <= 24'sh0;
                    curr_upd_r <= 1'b1;
                    if (((sum_r + 24'(sample_i)) >>> AVG_LOG2) > 24'(CURR_MAX))
                        curr_r <= CURR_MAX;
                    else if (((sum_r + 24'(sample_i)) >>> AVG_LOG2) < 24'(CURR_MIN))
                        curr_r <= CURR_MIN;
                    else
                        curr_r <= 12'((sum_r + 24'(sample_i)) >>> AVG_LOG2);
                end
                else
                    sum_r <= sum_r + 24'(sample_i);
            end
        end
    end

    //--------------------------------------------------------------
    // current accumulator
    //--------------------------------------------------------------
    // signed mean feeds a residue; whole units step the register
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            acc_r  <= 16'sh0;
            frac_r <= 20'sh0;
        end
        else if (wr_en && idx == IDX_ACC)
        begin
            acc_r  <= pwdata_i[15:0];
            frac_r <= 20'sh0;
        end
        else if (curr_upd_r)
        begin
            if (frac_r + 20'(curr_r) >= 20'(ACC_UNIT))
            begin
                acc_r  <= acc_r + 16'sh1;
                frac_r <= frac_r + 20'(curr_r) - 20'(ACC_UNIT);
            end
            else if (frac_r + 20'(curr_r) <= -20'(ACC_UNIT))
            begin
                acc_r  <= acc_r - 16'sh1;
                frac_r <= frac_r + 20'(curr_r) + 20'(ACC_UNIT);
            end
            else
                frac_r <= frac_r + 20'(curr_r);
        end
    end

    assign pready_o  = pready_r;
    assign prdata_o  = prdata_r;
    assign pslverr_o = pslverr_r;
endmodule

// File: test/cppm_properties.sv
`timescale 1ns/1ps
module cppm_properties
    import cppm_pkg::*;
#(
    parameter int OVD_CYCLES = OVD_CYC,
    parameter int UVD_CYCLES = UVD_CYC,
    parameter int OCD_CYCLES = OCD_CYC
) (
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pready_o,
    input  wire logic                  pslverr_o,
    input  wire cppm_pkg::cppm_sense_t sense_i,
    input  wire logic                  power_switch_input_n_i,
    input  wire logic                  charge_fet_off_o,
    input  wire logic                  discharge_fet_off_o,
    input  wire logic                  pls_pulldown_o,
    input  wire logic                  pls_pullup_o,
    input  wire logic                  sleep_o
);
    int ov_c;
    int uv_c;
    int oc_c;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // ------------------------------------
    // run length of overvoltage, undervoltage and charge overcurrent while awake
    // ------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        ov_c <= (!rst_n_i || sleep_o || !sense_i.cell_above_ov) ? 0 : ov_c + 1;
        uv_c <= (!rst_n_i || sleep_o || !sense_i.cell_below_uv) ? 0 : uv_c + 1;
        oc_c <= (!rst_n_i || sleep_o || !sense_i.sense_over_pos) ? 0 : oc_c + 1;
    end
    // ------------------------------------
    // register bus and protection checks
    // ------------------------------------
    chk_apb_answer: assert property ($rose(penable_i) && psel_i |=> pready_o ##1 !pready_o)
        else $error("bus answer late or too long");
    chk_apb_err: assert property (pslverr_o |-> pready_o)
        else $error("error flag without ready");
    chk_sleep_fets: assert property ($past(sleep_o) |-> charge_fet_off_o && discharge_fet_off_o)
        else $error("fet left on in sleep");
    chk_ov_trip: assert property (ov_c == OVD_CYCLES |-> ##[1:3] charge_fet_off_o)
        else $error("overvoltage did not stop charge");
    chk_uv_sleep: assert property (uv_c == UVD_CYCLES |-> ##[1:3] sleep_o)
        else $error("undervoltage did not sleep");
    chk_oc_trip: assert property (oc_c == OCD_CYCLES |-> ##[1:3] (charge_fet_off_o && discharge_fet_off_o))
        else $error("charge overcurrent did not trip");
    chk_ps_wake: assert property (sleep_o && !power_switch_input_n_i |-> ##[1:3] !sleep_o)
        else $error("power switch did not wake");
    chk_pull_down: assert property (pls_pulldown_o && $past(pls_pulldown_o) |-> charge_fet_off_o)
        else $error("charge on during pull down test");
    chk_pull_up: assert property (pls_pullup_o && $past(pls_pullup_o) |-> discharge_fet_off_o)
        else $error("discharge on during pull up test");
    cov_ov: cover property (ov_c == OVD_CYCLES);
    cov_wake: cover property (sleep_o ##1 !sleep_o);
    cov_err: cover property (pslverr_o);
endmodule

bind cppm_top cppm_properties #(.OVD_CYCLES(OVD_CYCLES), .UVD_CYCLES(UVD_CYCLES),
    .OCD_CYCLES(OCD_CYCLES)) u_props (.core_clk_i, .rst_n_i, .psel_i, .penable_i,
    .pready_o, .pslverr_o, .sense_i, .power_switch_input_n_i, .charge_fet_off_o,
    .discharge_fet_off_o, .pls_pulldown_o, .pls_pullup_o, .sleep_o);

// File: test/cppm_pack_model.sv
`timescale 1ns/1ps
module cppm_pack_model (
    input  wire logic unplug_i,
    input  wire logic fault_gone_i,
    input  wire logic pls_pulldown_i,
    input  wire logic pls_pullup_i,
    output logic      bus_data_o,
    output logic      pls_low_o,
    output logic      pls_high_o
);
    // host idles the line high; once unplugged the pull-down wins
    assign bus_data_o = !unplug_i;
    // pack terminal follows a test current only once the fault is gone
    assign pls_low_o  = fault_gone_i && pls_pulldown_i;
    assign pls_high_o = fault_gone_i && pls_pullup_i;
endmodule

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;
    import cppm_pkg::*;
    localparam int BL  = 50;
    localparam int OVD = 20;
    localparam int UVD = 20;
    localparam int OCD = 10;
    localparam int SCD = 2000;
    logic               clk = 0;
    logic               rst_n = 0;
    logic               psel = 0;
    logic               pen = 0;
    logic               pwr = 0;
    logic [9:0]         padr = '0;
    logic [31:0]        pwd = '0;
    logic               prdy;
    logic [31:0]        prd;
    logic               perr;
    cppm_sense_t        sn = '0;
    logic               ps_n = 1;
    logic               sv = 0;
    logic signed [15:0] smp = '0;
    logic               unplug = 0;
    logic               gone = 0;
    logic               chg_off;
    logic               dis_off;
    logic               pdn;
    logic               pup;
    logic               slp;
    logic               bus;
    logic               pls_lo;
    logic               pls_hi;
    int                 fail_count = 0;
    int                 cmp_count = 0;
    int                 acc;
    int                 res;
    int                 cur;
    int                 v;
    int                 q[$];
    logic [31:0]        rd;
    logic               er;
    // 20 MHz core clock
    always #25 clk = ~clk;
    // device with shortened delays, pack model on its far side
    cppm_top #(.BUS_LOW_CYCLES(BL), .OVD_CYCLES(OVD), .UVD_CYCLES(UVD),
        .OCD_CYCLES(OCD)) dut (.core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd),
        .pready_o(prdy), .prdata_o(prd), .pslverr_o(perr),
        .sense_i({sn[8:2], pls_lo, pls_hi}), .bus_data_i(bus),
        .power_switch_input_n_i(ps_n), .sample_valid_i(sv), .sample_i(smp),
        .charge_fet_off_o(chg_off), .discharge_fet_off_o(dis_off),
        .pls_pulldown_o(pdn), .pls_pullup_o(pup), .sleep_o(slp));
    cppm_pack_model pack (.unplug_i(unplug), .fault_gone_i(gone), .pls_pulldown_i(pdn),
        .pls_pullup_i(pup), .bus_data_o(bus), .pls_low_o(pls_lo), .pls_high_o(pls_hi));
    // ------------------------------------
    // compare, bus cycle, stimulus tasks
    // ------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD at %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        padr <= {idx, 2'b00};
        pwd <= wd;
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        while (prdy !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk);
        end
        if (n == 20)
            fail_count++;
        rd = prd;
        er = perr;
        psel <= 0;
        pen <= 0;
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        apb(0, idx, 0);
        check(rd, exp);
    endtask
    // n averaging periods of one reading; the model averages and accumulates
    task automatic feed(input int val, input int n);
        repeat (n * 128)
        begin
            @(posedge clk);
            smp <= 16'(val);
            sv <= 1;
            q.push_back(val);
            @(posedge clk);
            sv <= 0;
            if (q.size() == 128)
            begin
                cur = q.sum() / 128;
                cur = cur > 2047 ? 2047 : (cur < -2048 ? -2048 : cur);
                res += cur;
                acc += res >= ACC_UNIT ? 1 : (res <= -ACC_UNIT ? -1 : 0);
                res -= res >= ACC_UNIT ? ACC_UNIT : (res <= -ACC_UNIT ? -ACC_UNIT : 0);
                q.delete();
            end
        end
        repeat (4) @(posedge clk);
    endtask
    task give_verdict;
        if (fail_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // watchdog far beyond the expected run of about 8000 cycles
    initial
    begin
        #2_000_000;
        fail_count++;
        give_verdict();
    end
    // ------------------------------------
    // main sequence
    // ------------------------------------
    initial
    begin
        v = $urandom(23915);
        repeat (12) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        check({slp, chg_off, dis_off}, 3'b111);
        rdc(IDX_PROT, 32'(PROT_RST) | 32'h0c);
        apb(0, 8'h02, 0);
        check(er, 1);
        check(rd, 0);
        ps_n <= 0;
        repeat (4) @(posedge clk);
        ps_n <= 1;
        repeat (2) @(posedge clk);
        check({slp, chg_off, dis_off}, 0);
        v = $urandom_range(4095) - 2048;
        feed(v, 1);
        rdc(IDX_CURR, cur & 'hfff);
        feed(3000, 1);
        rdc(IDX_CURR, 32'h7ff);
        feed(-3000, 1);
        rdc(IDX_CURR, 32'h800);
        v = $urandom_range(16'hffff);
        apb(1, IDX_ACC, v);
        acc = v;
        res = 0;
        rdc(IDX_ACC, acc & 'hffff);
        feed(2047, 8);
        rdc(IDX_ACC, acc & 'hffff);
        feed(-2047, 9);
        rdc(IDX_ACC, acc & 'hffff);
        repeat (2)
        begin
            sn.cell_above_ov <= 1;
            repeat (OVD - 3) @(posedge clk);
            sn.cell_above_ov <= 0;
            @(posedge clk);
        end
        check(chg_off, 0);
        sn.cell_above_ov <= 1;
        repeat (OVD + 4) @(posedge clk);
        check({chg_off, dis_off}, 2'b10);
        sn.cell_above_ov <= 0;
        sn.cell_below_ce <= 1;
        repeat (4) @(posedge clk);
        check(chg_off, 0);
        rdc(IDX_PROT, 32'h83);
        apb(1, IDX_PROT, 32'h03);
        rdc(IDX_PROT, 32'h03);
        // charge, discharge and short faults, held past their delays
        for (int k = 0; k < 3; k++)
        begin
            sn[5 - k] <= 1;
            repeat ((k == 2 ? SCD : OCD) + 4) @(posedge clk);
            sn[5 - k] <= 0;
            repeat (6) @(posedge clk);
            check({chg_off, dis_off, pdn, pup}, k ? 4'b0101 : 4'b1110);
            gone <= 1;
            repeat (5) @(posedge clk);
            check({chg_off, dis_off, pdn, pup}, 0);
            gone <= 0;
            rdc(IDX_PROT, k ? 32'h13 : 32'h23);
            apb(1, IDX_PROT, 32'h03);
        end
        for (int p = 1; p < 3; p++)
        begin
            apb(1, IDX_PROT, p);
            repeat (3) @(posedge clk);
            check({chg_off, dis_off}, {30'h0, ~p[1:0]});
        end
        apb(1, IDX_PROT, 32'h03);
        apb(1, IDX_STAT, 32'h08);
        apb(1, IDX_SPEC, 32'h02);
        repeat (3) @(posedge clk);
        check(slp, 1);
        apb(1, IDX_SPEC, 32'h01);
        repeat (3) @(posedge clk);
        check(slp, 0);
        apb(1, IDX_STAT, 32'h20);
        unplug <= 1;
        repeat (BL + 5) @(posedge clk);
        check(slp, 1);
        unplug <= 0;
        repeat (4) @(posedge clk);
        check(slp, 0);
        apb(1, IDX_STAT, 32'h00);
        sn.cell_below_uv <= 1;
        repeat (UVD + 4) @(posedge clk);
        check({slp, chg_off, dis_off}, 3'b111);
        sn.cell_below_uv <= 0;
        rdc(IDX_PROT, 32'h4f);
        sn.charger_present <= 1;
        repeat (4) @(posedge clk);
        check(slp, 0);
        give_verdict();
    end
endmodule
